// ### rtl/rsx_consts.svh
// Purpose: Offsets, field positions and timing figures of the receive signaling block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes: Definitions only
`ifndef RSX_CONSTS_SVH
`define RSX_CONSTS_SVH

// ****************************************
// Register indices (framer one)
// ****************************************
`define RSX_IDX_SIGC 12'h013
`define RSX_IDX_AONE 12'h038
`define RSX_AONE_REGS 2'h3
`define RSX_IDX_RS 12'h040
`define RSX_IDX_LS4 12'h093
`define RSX_IDX_SS 12'h098
`define RSX_IDX_IM4 12'h0A3
`define RSX_IDX_CSE 12'h0A8
`define RSX_IDX_RSI 12'h0C8
`define RSX_IDX_CFG 12'h0F0
`define RSX_FRAMER_STRIDE 12'h200

// ****************************************
// Field positions
// ****************************************
`define RSX_BIT_COS 3
`define RSX_BIT_FRZ_EN 1
`define RSX_BIT_FRZ_FORCE 2

// ****************************************
// Framing and timing
// ****************************************
`define RSX_CLK_MHZ 100
`define RSX_HOLD_ESF_US 9000
`define RSX_HOLD_D4_US 4500
`define RSX_HOLD_E1_US 6000
`define RSX_INTEG_MF 2'h3
`define RSX_MF_ESF 5'd24
`define RSX_MF_D4 5'd12
`define RSX_MF_E1 5'd16
`define RSX_ROB_PERIOD 6
`define RSX_TS16 5'd16
`define RSX_HALF_E1 5'd16
`define RSX_HALF_T1 5'd12
`define RSX_T1_CHANS 5'd24
`define RSX_LAST_1544 8'd192
`define RSX_LAST_2048 8'hFF

`endif

// ### rtl/rsx_pkg.sv
// Purpose: Types shared by the receive signaling block
// Assumes: Nothing
// Notes: Structs carry pin groups and configuration
package rsx_pkg;
	typedef struct packed {
		logic mf_start;
		logic valid;
		logic [4:0] chan;
		logic [3:0] abcd;
	} rsx_line_t;
	typedef struct packed {
		logic bp2048;
		logic es_en;
		logic integ;
		logic d4;
		logic e1;
	} rsx_cfg_t;
endpackage

// ### rtl/rsx_sig_buf.sv
// Purpose: Four-multiframe signaling store, 32 channels of ABCD per page
// Assumes: Single clock, one write and one read port
// Notes: Read data registered, one cycle latency
`timescale 1ns/1ps
module rsx_sig_buf (
	// Clock
	input wire logic clk_i,
	// Write port
	input wire logic wr_en_i,
	input wire logic [6:0] wr_addr_i,
	input wire logic [3:0] wr_data_i,
	// Read port
	input wire logic [6:0] rd_addr_i,
	output logic [3:0] rd_data_o
);
	logic [3:0] mem [128];

	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule

// ### rtl/rsx_sig_freeze.sv
// Purpose: Receive signaling capture, change of state, buffer, reinsertion, freeze
// Assumes: Line and backplane clocks are slow pins sampled by clk_i
// Notes: Registers are bytes on a 32-bit Wishbone word each
// Function
// RL1: Copy signaling to registers each multiframe
// RL2: Only enabled channels raise change indication
// RL3: Change sets latched status four bit three
// RL4: Integration needs three stable multiframes
// RL5: Masked-in change drives interrupt low
// RL6: Integration setting is global
// RL7: Change status records every channel
// RL8: Serial signaling stream, data left intact
// RL9: Works with elastic store on or off
// RL10: ESF ABCD in lower nibble
// RL11: Stream updated once per multiframe unless frozen
// RL12: D4 repeats AB in lower nibble
// RL13: Backplane sync aligns reinserted signaling
// RL14: Reinsert only selected channels
// RL15: Reinsertion needs elastic store, E1 2.048
// RL16: T1 selected channels forced all ones
// RL17: Freeze on frame or carrier faults
// RL18: Force bit freezes unconditionally
// RL19: Freeze indicator pin while frozen
// RL20: Four-page buffer, three multiframe delay
// RL21: Hold old signaling after cause clears
// RL22: Registers hold during loss of frame
// RL23: Register block at framer index offset
// RL24: Latched bit sticky, interrupt follows it
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`include "rsx_consts.svh"
module rsx_sig_freeze import rsx_pkg::*; #(
	parameter int FRAMER_IDX = 1,
	parameter int HOLD_ESF = `RSX_HOLD_ESF_US * `RSX_CLK_MHZ,
	parameter int HOLD_D4 = `RSX_HOLD_D4_US * `RSX_CLK_MHZ,
	parameter int HOLD_E1 = `RSX_HOLD_E1_US * `RSX_CLK_MHZ
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [13:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Line side pins
	input wire logic rx_line_clk_i,
	input wire rsx_line_t line_i,
	input wire logic out_of_frame_i,
	input wire logic loss_of_frame_i,
	input wire logic carrier_loss_i,
	input wire logic align_change_i,
	// Backplane pins
	input wire logic rx_backplane_clk_i,
	input wire logic rx_multiframe_sync_i,
	input wire logic rx_ser_i,
	output logic rx_serial_out_o,
	output logic rx_sig_stream_out_o,
	// Indicators
	output logic irq_n_out_o,
	output logic freeze_indicator_out_o
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [7:0] get_byte(logic [31:0] v, logic [1:0] k);
		get_byte = v[k*8 +: 8];
	endfunction

	function automatic logic [31:0] put_byte(logic [31:0] v, logic [1:0] k, logic [7:0] d);
		put_byte = v;
		put_byte[k*8 +: 8] = d;
	endfunction

	function automatic logic [3:0] get_nib(logic [127:0] v, logic [4:0] ch);
		get_nib = v[ch*4 +: 4];
	endfunction

	function automatic logic in_grp4(logic [11:0] i, logic [11:0] b);
		in_grp4 = (i[11:2] == b[11:2]);
	endfunction

	// Robbed-bit frame flag and ABCD index for zero-based frame f
	function automatic logic [2:0] rob_pos(logic [4:0] f);
		int fn;
		fn = int'(f) + 1;
		rob_pos = {fn % `RSX_ROB_PERIOD == 0, 2'(fn / `RSX_ROB_PERIOD - 1)};
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [18:0] pins;
	logic [18:0] sync1_reg;
	logic [18:0] sync2_reg;
	logic lclk_d_reg;
	logic bclk_d_reg;
	assign pins = {rx_line_clk_i, line_i, out_of_frame_i, loss_of_frame_i, carrier_loss_i,
		align_change_i, rx_backplane_clk_i, rx_multiframe_sync_i, rx_ser_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			lclk_d_reg <= 1'b0;
			bclk_d_reg <= 1'b0;
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
			lclk_d_reg <= sync2_reg[18];
			bclk_d_reg <= sync2_reg[2];
		end
	end

	rsx_line_t line_s;
	logic oof_s, lof_s, cl_s, al_s, msync_s, ser_s, line_edge, bedge;
	assign line_s = rsx_line_t'(sync2_reg[17:7]);
	assign {oof_s, lof_s, cl_s, al_s} = sync2_reg[6:3];
	assign {msync_s, ser_s} = sync2_reg[1:0];
	assign line_edge = sync2_reg[18] && !lclk_d_reg;
	assign bedge = sync2_reg[2] && !bclk_d_reg;

	// ****************************************
	// Registers and signaling capture
	// ****************************************
	logic [7:0] ctl_reg, ctl_next;
	logic [31:0] aone_reg, aone_next, cse_reg, cse_next, rsi_reg, rsi_next, css_reg, css_next;
	logic ls4_reg, ls4_next, im4_reg, im4_next, irq_next, ack_next;
	rsx_cfg_t cfg_reg, cfg_next;
	logic [127:0] stage_reg, stage_next, prev_reg, prev_next, rep_reg, rep_next;
	logic [127:0] rs_reg, rs_next;
	logic [63:0] cnt_reg, cnt_next;
	logic [31:0] dat_next;
	logic [11:0] ridx;
	logic [7:0] rd_byte, wd;
	logic [4:0] half;
	logic acc, wr, cos_hit, line_mf;
	logic [3:0] cap_v;
	logic [1:0] cap_c;

	assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = acc && wb_we_i && wb_sel_i[0];
	assign wd = wb_dat_i[7:0];
	assign ridx = wb_adr_i[13:2] - 12'((FRAMER_IDX - 1) * `RSX_FRAMER_STRIDE); // see RL23
	assign half = cfg_reg.e1 ? `RSX_HALF_E1 : `RSX_HALF_T1;
	assign line_mf = line_edge && line_s.mf_start;

	always_comb begin
		rd_byte = 8'h00;
		if (ridx == `RSX_IDX_SIGC) begin
			rd_byte = ctl_reg;
		end else if (in_grp4(ridx, `RSX_IDX_AONE)) begin
			rd_byte = get_byte(aone_reg, ridx[1:0]);
		end else if (ridx[11:4] == `RSX_IDX_RS >> 4) begin
			rd_byte = {get_nib(rs_reg, {1'b0, ridx[3:0]}),
				get_nib(rs_reg, 5'({1'b0, ridx[3:0]} + half))};
		end else if (ridx == `RSX_IDX_LS4) begin
			rd_byte[`RSX_BIT_COS] = ls4_reg;
		end else if (in_grp4(ridx, `RSX_IDX_SS)) begin
			rd_byte = get_byte(css_reg, ridx[1:0]);
		end else if (ridx == `RSX_IDX_IM4) begin
			rd_byte[`RSX_BIT_COS] = im4_reg;
		end else if (in_grp4(ridx, `RSX_IDX_CSE)) begin
			rd_byte = get_byte(cse_reg, ridx[1:0]);
		end else if (in_grp4(ridx, `RSX_IDX_RSI)) begin
			rd_byte = get_byte(rsi_reg, ridx[1:0]);
		end else if (ridx == `RSX_IDX_CFG) begin
			rd_byte[$bits(rsx_cfg_t)-1:0] = cfg_reg;
		end
	end

	always_comb begin
		ctl_next = ctl_reg;
		aone_next = aone_reg;
		cse_next = cse_reg;
		rsi_next = rsi_reg;
		css_next = css_reg;
		ls4_next = ls4_reg;
		im4_next = im4_reg;
		cfg_next = cfg_reg;
		stage_next = stage_reg;
		prev_next = prev_reg;
		rep_next = rep_reg;
		rs_next = rs_reg;
		cnt_next = cnt_reg;
		cos_hit = 1'b0;
		cap_v = 4'h0;
		cap_c = 2'h0;
		ack_next = acc;
		dat_next = (acc && !wb_we_i) ? {24'h000000, rd_byte} : 32'h00000000;
		if (wr) begin
			if (ridx == `RSX_IDX_SIGC) ctl_next = wd;
			if (in_grp4(ridx, `RSX_IDX_AONE) && ridx[1:0] < `RSX_AONE_REGS) begin
				aone_next = put_byte(aone_reg, ridx[1:0], wd);
			end
			if (in_grp4(ridx, `RSX_IDX_CSE)) cse_next = put_byte(cse_reg, ridx[1:0], wd);
			if (in_grp4(ridx, `RSX_IDX_RSI)) rsi_next = put_byte(rsi_reg, ridx[1:0], wd);
			if (ridx == `RSX_IDX_IM4) im4_next = wd[`RSX_BIT_COS];
			if (ridx == `RSX_IDX_CFG) cfg_next = rsx_cfg_t'(wd[$bits(rsx_cfg_t)-1:0]);
			// Write one to clear; sets below win
			if (ridx == `RSX_IDX_LS4 && wd[`RSX_BIT_COS]) ls4_next = 1'b0; // see RL24
			if (in_grp4(ridx, `RSX_IDX_SS)) begin
				css_next = put_byte(css_reg, ridx[1:0], get_byte(css_reg, ridx[1:0]) & ~wd);
			end
		end
		if (line_edge && line_s.valid) begin
			stage_next[line_s.chan*4 +: 4] = line_s.abcd;
		end
		// Boundary: skipped during loss of frame so registers keep last good data
		if (line_mf && !lof_s) begin // see RL22
			for (int i = 0; i < 32; i++) begin
				cap_v = stage_reg[i*4 +: 4];
				cap_c = cnt_reg[i*2 +: 2];
				if (cap_v != prev_reg[i*4 +: 4]) begin
					cap_c = 2'h1;
				end else if (cap_c != `RSX_INTEG_MF) begin
					cap_c = cap_c + 2'h1;
				end
				cnt_next[i*2 +: 2] = cap_c;
				prev_next[i*4 +: 4] = cap_v;
				rs_next[i*4 +: 4] = cap_v; // see RL1
				// One global integration switch for every channel
				if (cap_v != rep_reg[i*4 +: 4] &&
					(!cfg_reg.integ || cap_c == `RSX_INTEG_MF)) begin // see RL4, RL6
					rep_next[i*4 +: 4] = cap_v;
					css_next[i] = 1'b1; // see RL7
					if (cse_reg[i]) cos_hit = 1'b1; // see RL2
				end
			end
		end
		if (cos_hit) ls4_next = 1'b1; // see RL3
		irq_next = !(ls4_reg && im4_reg); // see RL5, RL24
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_reg <= 8'h00;
			aone_reg <= 32'h00000000;
			cse_reg <= 32'h00000000;
			rsi_reg <= 32'h00000000;
			css_reg <= 32'h00000000;
			ls4_reg <= 1'b0;
			im4_reg <= 1'b0;
			cfg_reg <= '0;
			stage_reg <= '0;
			prev_reg <= '0;
			rep_reg <= '0;
			rs_reg <= '0;
			cnt_reg <= '0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			irq_n_out_o <= 1'b1;
		end else begin
			ctl_reg <= ctl_next;
			aone_reg <= aone_next;
			cse_reg <= cse_next;
			rsi_reg <= rsi_next;
			css_reg <= css_next;
			ls4_reg <= ls4_next;
			im4_reg <= im4_next;
			cfg_reg <= cfg_next;
			stage_reg <= stage_next;
			prev_reg <= prev_next;
			rep_reg <= rep_next;
			rs_reg <= rs_next;
			cnt_reg <= cnt_next;
			wb_ack_o <= ack_next;
			wb_dat_o <= dat_next;
			irq_n_out_o <= irq_next;
		end
	end

	// ****************************************
	// Freeze control
	// ****************************************
	logic [19:0] hold_reg, hold_next;
	logic [1:0] wr_page_reg, wr_page_next;
	logic frz_cause, frz_now, frz_next;

	assign frz_cause = (ctl_reg[`RSX_BIT_FRZ_EN] && (oof_s || cl_s || al_s)) ||
		ctl_reg[`RSX_BIT_FRZ_FORCE]; // see RL17, RL18
	assign frz_now = frz_cause || hold_reg != 20'h00000;

	always_comb begin
		hold_next = hold_reg;
		wr_page_next = wr_page_reg;
		// Hold time reloads while the cause stands, counts after it clears
		if (frz_cause) begin // see RL21
			hold_next = cfg_reg.e1 ? 20'(HOLD_E1) : cfg_reg.d4 ? 20'(HOLD_D4) : 20'(HOLD_ESF);
		end else if (hold_reg != 20'h00000) begin
			hold_next = hold_reg - 20'h00001;
		end
		if (line_mf && !frz_now) wr_page_next = wr_page_reg + 2'h1; // see RL20
		frz_next = frz_now; // see RL19
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hold_reg <= 20'h00000;
			wr_page_reg <= 2'h0;
			freeze_indicator_out_o <= 1'b0;
		end else begin
			hold_reg <= hold_next;
			wr_page_reg <= wr_page_next;
			freeze_indicator_out_o <= frz_next;
		end
	end

	// ****************************************
	// Signaling store and backplane side
	// ****************************************
	logic [7:0] bit_reg, bit_next, last_bit, tbit, sbyte;
	logic [4:0] frm_reg, frm_next, frames, slot, rd_ch;
	logic [1:0] rd_page_reg, rd_page_next;
	logic [2:0] bpos, rob;
	logic [3:0] mem_q, nib;
	logic ser_next, sig_next, fbit, reins_ok;

	rsx_sig_buf u_buf (
		.clk_i(clk_i),
		.wr_en_i(line_edge && line_s.valid && !frz_now), // see RL17
		.wr_addr_i({wr_page_reg, line_s.chan}),
		.wr_data_i(line_s.abcd),
		.rd_addr_i({rd_page_reg, rd_ch}),
		.rd_data_o(mem_q)
	);

	assign last_bit = cfg_reg.bp2048 ? `RSX_LAST_2048 : `RSX_LAST_1544; // see RL9
	assign frames = cfg_reg.e1 ? `RSX_MF_E1 : cfg_reg.d4 ? `RSX_MF_D4 : `RSX_MF_ESF;
	assign fbit = !cfg_reg.bp2048 && bit_reg == 8'h00;
	assign tbit = cfg_reg.bp2048 ? bit_reg : bit_reg - 8'h01;
	assign slot = tbit[7:3];
	assign bpos = tbit[2:0];
	assign rd_ch = (cfg_reg.e1 && slot == `RSX_TS16) ? (bpos[2] ? 5'(frm_reg + `RSX_HALF_E1) :
		frm_reg) : slot;
	assign rob = rob_pos(frm_reg);
	assign nib = (!cfg_reg.e1 && aone_reg[rd_ch]) ? 4'hF : mem_q; // see RL16
	// Sample is always in the lower nibble: ABCD, except D4, which repeats AB
	assign sbyte = cfg_reg.d4 ? {4'h0, nib[3:2], nib[3:2]} : {4'h0, nib}; // see RL10, RL12
	// E1 into a 1.544 backplane is never reinserted
	assign reins_ok = cfg_reg.es_en && rsi_reg[rd_ch] && (cfg_reg.bp2048 || !cfg_reg.e1); // see RL15

	always_comb begin
		bit_next = bit_reg;
		frm_next = frm_reg;
		rd_page_next = rd_page_reg;
		ser_next = rx_serial_out_o;
		sig_next = rx_sig_stream_out_o;
		if (bedge) begin
			sig_next = fbit ? 1'b0 : sbyte[~bpos]; // see RL8
			ser_next = ser_s;
			if (!cfg_reg.e1 && !fbit && slot < `RSX_T1_CHANS && rob[2] && bpos == 3'h7 &&
				(reins_ok || aone_reg[rd_ch])) begin // see RL14, RL16
				ser_next = nib[~rob[1:0]];
			end
			if (cfg_reg.e1 && slot == `RSX_TS16 && frm_reg != 5'h00 && reins_ok) begin // see RL14
				ser_next = nib[~bpos[1:0]];
			end
			// Sync marks the next bit as frame zero, bit zero
			if (msync_s || (bit_reg == last_bit && frm_reg == frames - 5'h01)) begin // see RL13
				bit_next = 8'h00;
				frm_next = 5'h00;
				// Older page three multiframes back; held while frozen
				if (!frz_now) rd_page_next = wr_page_reg + 2'h1; // see RL11, RL20
			end else if (bit_reg == last_bit) begin
				bit_next = 8'h00;
				frm_next = frm_reg + 5'h01;
			end else begin
				bit_next = bit_reg + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bit_reg <= 8'h00;
			frm_reg <= 5'h00;
			rd_page_reg <= 2'h0;
			rx_serial_out_o <= 1'b0;
			rx_sig_stream_out_o <= 1'b0;
		end else begin
			bit_reg <= bit_next;
			frm_reg <= frm_next;
			rd_page_reg <= rd_page_next;
			rx_serial_out_o <= ser_next;
			rx_sig_stream_out_o <= sig_next;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_irq_low: assert property ((ls4_reg && im4_reg) |=> !irq_n_out_o) // see RL5
		else $error("interrupt not driven low");
	chk_irq_release: assert property (!(ls4_reg && im4_reg) |=> irq_n_out_o) // see RL24
		else $error("interrupt not released");
	chk_ls4_sticky: assert property (ls4_reg && !(wr && ridx == `RSX_IDX_LS4) |=> ls4_reg) // see RL24
		else $error("latched change bit lost");
	chk_cos_cause: assert property ($rose(ls4_reg) |-> $past(cos_hit)) // see RL2, RL3
		else $error("change bit set without enabled change");
	chk_freeze_pin: assert property (frz_cause |=> freeze_indicator_out_o) // see RL19
		else $error("freeze pin not asserted");
	chk_hold_min: assert property ($fell(frz_cause) |=> freeze_indicator_out_o[*8]) // see RL21
		else $error("freeze released too early");
	chk_page_frozen: assert property (frz_now |=> $stable(wr_page_reg)) // see RL17
		else $error("buffer advanced while frozen");
	chk_rs_lof: assert property (lof_s |=> $stable(rs_reg)) // see RL22
		else $error("signaling registers changed in loss of frame");
	chk_rd_delay: assert property ($changed(rd_page_reg) |-> rd_page_reg == $past(wr_page_reg) + 2'h1) // see RL20
		else $error("read page not three behind");
	chk_css_record: assert property ((line_mf && !lof_s && stage_reg != rep_reg && !cfg_reg.integ)
		|=> css_reg != 32'h00000000) // see RL7
		else $error("change not recorded");

	cov_cos: cover property ($rose(ls4_reg));
	cov_freeze: cover property ($fell(freeze_indicator_out_o));
	cov_sync: cover property (bedge && msync_s);
	cov_reinsert: cover property (bedge && reins_ok && rob[2] && bpos == 3'h7);
endmodule

// ### sim/rsx_line_model.sv
// Purpose: Line-side model feeding recovered signaling samples to the block
// Assumes: Line clock runs only while samples are sent, 80 ns period
// Notes: Released data is inverted so a stale sample never repeats the one sent
`timescale 1ns/1ps
module rsx_line_model import rsx_pkg::*; (
	// Line pins toward the block
	output rsx_line_t line_o,
	output logic line_clk_o
);
	initial begin
		line_o = '0;
		line_clk_o = 1'b0;
	end

	// One sample per line clock; clock idles low between frames
	task automatic send(input logic [4:0] ch, input logic [3:0] v, input logic mf);
		// Every change lands between clock edges; one assignment per time step
		#1 line_o = '{mf_start: mf, valid: ~mf, chan: ch, abcd: v};
		#37 line_clk_o = 1'b1;
		#40 line_clk_o = 1'b0;
		// Scramble after the hold so the block cannot lean on old data
		#1 line_o = ~line_o;
		#1;
	endtask
endmodule

// ### sim/tb_rx_signaling_extract_freeze.sv
// Purpose: Self-checking bench for the receive signaling block
// Assumes: T1 ESF framing, framer one, short hold parameter
// Notes: Reference arrays track accepted signaling and change bits
`timescale 1ns/1ps
module tb_rx_signaling_extract_freeze;
	localparam int HOLD = 20;
	logic clk_i;
	logic rst_i;
	logic wb_cyc_i, wb_stb_i, wb_we_i;
	logic [13:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0] wb_sel_i;
	logic wb_ack_o, line_clk, out_of_frame, loss_of_frame, bp_clk, ser_o, sig_o, irq_n, frz;
	logic cl, al, msync, rx_ser, bp_d, bp_live, sync_req;
	logic [7:0] aone_v;
	int bp_bit, bp_frm;
	rsx_pkg::rsx_line_t line;
	int error_cnt, comparisons, cyc_cnt, seed;
	logic [3:0] sent [24];
	logic [3:0] acc [24];
	logic [23:0] chg;

	rsx_sig_freeze #(.HOLD_ESF(HOLD), .HOLD_D4(HOLD), .HOLD_E1(HOLD)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_line_clk_i(line_clk), .line_i(line),
		.out_of_frame_i(out_of_frame), .loss_of_frame_i(loss_of_frame), .carrier_loss_i(cl),
		.align_change_i(al), .rx_backplane_clk_i(bp_clk), .rx_multiframe_sync_i(msync),
		.rx_ser_i(rx_ser), .rx_serial_out_o(ser_o), .rx_sig_stream_out_o(sig_o),
		.irq_n_out_o(irq_n), .freeze_indicator_out_o(frz));
	rsx_line_model line_m (.line_o(line), .line_clk_o(line_clk));

	// ****************************************
	// Clocks and hang guard
	// ****************************************
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		bp_clk = 1'b0;
		forever #40 bp_clk = ~bp_clk;
	end
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// ****************************************
	// Backplane partner
	// ****************************************
	// Sync and data move just after the backplane clock falls, so they are steady at its rise
	always @(posedge clk_i) begin
		bp_d <= bp_clk;
		if (bp_d && !bp_clk) begin
			if (bp_live && bp_bit == 0) begin
				chk("stream F bit", {31'h0, sig_o}, 32'h0);
				chk("serial F bit", {31'h0, ser_o}, {31'h0, rx_ser});
			end else if (bp_live) begin
				if ((bp_bit - 1) % 8 < 4) begin
					chk("stream upper nibble", {31'h0, sig_o}, 32'h0);
				end else if (forced(bp_bit)) begin
					chk("stream forced nibble", {31'h0, sig_o}, 32'h1);
				end
				if (forced(bp_bit) && (bp_bit - 1) % 8 == 7 && (bp_frm + 1) % 6 == 0) begin
					chk("serial robbed bit", {31'h0, ser_o}, 32'h1);
				end else begin
					chk("serial data", {31'h0, ser_o}, {31'h0, rx_ser});
				end
			end
			// Sync for one bit makes the following bit frame zero, bit zero
			if (msync) begin
				bp_bit <= 0;
				bp_frm <= 0;
			end else if (bp_bit == 192) begin
				bp_bit <= 0;
				bp_frm <= (bp_frm == 23) ? 0 : bp_frm + 1;
			end else begin
				bp_bit <= bp_bit + 1;
			end
			bp_live <= bp_live || msync;
			msync <= sync_req && !msync && !bp_live;
			rx_ser <= 1'($random(seed));
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= {idx, 2'h0};
		wb_dat_i <= {24'h000000, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		wb_sel_i <= 4'h0;
	endtask
	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, idx, d, q);
	endtask
	task automatic rd_chk(input string what, input logic [11:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, idx, 8'h00, q);
		chk(what, q, exp);
	endtask
	// Whole multiframe: all 24 channels, then the boundary marker
	task automatic send_mf;
		for (int c = 0; c < 24; c++) begin
			line_m.send(5'(c), sent[c], 1'b0);
		end
		line_m.send(5'h00, 4'h0, 1'b1);
		repeat (12) @(posedge clk_i);
	endtask
	task automatic accept;
		for (int c = 0; c < 24; c++) begin
			chg[c] = chg[c] | (sent[c] != acc[c]);
			acc[c] = sent[c];
		end
	endtask
	task automatic check_regs;
		for (int k = 0; k < 12; k++) begin
			rd_chk("sig reg", 12'h040 + 12'(k), {24'h000000, acc[k], acc[k + 12]});
		end
	endtask
	task automatic check_chg;
		for (int j = 0; j < 3; j++) begin
			rd_chk("chg status", 12'h098 + 12'(j), {24'h000000, chg[8 * j +: 8]});
		end
	endtask
	// Backplane bit 1..64 falls in a T1 channel 0..7 whose all-ones bit is set
	function automatic logic forced(input int b);
		forced = b >= 1 && b <= 64 && aone_v[(b - 1) / 8];
	endfunction
	task automatic tally_and_finish;
		$display("Counts: %0d mismatches in %0d comparisons", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [31:0] r;
		seed = 3708;
		error_cnt = 0;
		comparisons = 0;
		cyc_cnt = 0;
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, out_of_frame, loss_of_frame, cl, al, msync, rx_ser, bp_d, bp_live,
			sync_req} = 12'h000;
		aone_v = 8'h00;
		bp_bit = 0;
		bp_frm = 0;
		wb_adr_i = 14'h0000;
		wb_dat_i = 32'h00000000;
		wb_sel_i = 4'h0;
		chg = 24'h000000;
		for (int c = 0; c < 24; c++) begin
			acc[c] = 4'h0;
		end
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("irq_n", {31'h0, irq_n}, 32'h1);
		chk("freeze pin", {31'h0, frz}, 32'h0);
		rd_chk("ctl", 12'h013, 32'h0);
		rd_chk("latched", 12'h093, 32'h0);
		wr(12'h001, 8'h5A);
		rd_chk("unmapped", 12'h001, 32'h0);
		r = $random(seed);
		// Channel zero always forced so the robbed-bit check has work to do
		r[0] = 1'b1;
		wr(12'h038, r[7:0]);
		aone_v = r[7:0];
		sync_req <= 1'b1;
		rd_chk("force ones", 12'h038, {24'h000000, r[7:0]});
		wr(12'h0A8, 8'h01);
		wr(12'h0A3, 8'h08);
		// Changes on disabled channels only: status yes, latched no
		for (int c = 0; c < 24; c++) begin
			sent[c] = 4'($random(seed));
		end
		sent[0] = 4'h0;
		sent[5] = 4'hA;
		send_mf();
		accept();
		check_regs();
		check_chg();
		rd_chk("latched", 12'h093, 32'h0);
		chk("irq_n", {31'h0, irq_n}, 32'h1);
		for (int j = 0; j < 3; j++) begin
			wr(12'h098 + 12'(j), 8'hFF);
		end
		chg = 24'h000000;
		sent[0] = 4'h5;
		send_mf();
		accept();
		check_chg();
		rd_chk("latched", 12'h093, 32'h8);
		chk("irq_n", {31'h0, irq_n}, 32'h0);
		wr(12'h093, 8'h08);
		rd_chk("latched", 12'h093, 32'h0);
		chk("irq_n", {31'h0, irq_n}, 32'h1);
		// Registers must hold through loss of frame
		loss_of_frame <= 1'b1;
		repeat (6) @(posedge clk_i);
		for (int c = 0; c < 24; c++) begin
			sent[c] = ~acc[c];
		end
		send_mf();
		check_regs();
		loss_of_frame <= 1'b0;
		// Integration: report only on the third stable boundary
		wr(12'h0F0, 8'h04);
		for (int c = 0; c < 24; c++) begin
			sent[c] = acc[c];
		end
		sent[0] = 4'hC;
		send_mf();
		rd_chk("latched", 12'h093, 32'h0);
		send_mf();
		send_mf();
		rd_chk("latched", 12'h093, 32'h8);
		// Freeze: forced, then fault-driven, then hold after the fault clears
		wr(12'h013, 8'h04);
		repeat (6) @(posedge clk_i);
		chk("freeze pin", {31'h0, frz}, 32'h1);
		out_of_frame <= 1'b1;
		wr(12'h013, 8'h02);
		repeat (6) @(posedge clk_i);
		chk("freeze pin", {31'h0, frz}, 32'h1);
		out_of_frame <= 1'b0;
		repeat (12) @(posedge clk_i);
		chk("freeze pin", {31'h0, frz}, 32'h1);
		repeat (30) @(posedge clk_i);
		chk("freeze pin", {31'h0, frz}, 32'h0);
		cl <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("freeze pin", {31'h0, frz}, 32'h1);
		cl <= 1'b0;
		repeat (30) @(posedge clk_i);
		al <= 1'b1;
		chk("freeze pin", {31'h0, frz}, 32'h0);
		repeat (6) @(posedge clk_i);
		chk("freeze pin", {31'h0, frz}, 32'h1);
		al <= 1'b0;
		// Run on until the robbed-bit frame has passed the stream checks
		while (bp_frm < 6) begin
			@(posedge clk_i);
		end
		tally_and_finish();
	end
endmodule
